// ---- core/ssp_pkg.sv ----
package ssp_pkg;

  // Stack geometry
  localparam logic [15:0] SP_RESET  = 16'h1000;
  localparam logic [15:0] FP_RESET  = 16'h0000;
  localparam logic [15:0] WORD_STEP = 16'h0002;

  // Register byte offsets
  localparam logic [11:0] OFS_SP   = 12'h000;
  localparam logic [11:0] OFS_FP   = 12'h004;
  localparam logic [11:0] OFS_CTRL = 12'h008;
  localparam logic [11:0] OFS_STAT = 12'h00C;

  // Control and status fields
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam logic [15:0] CTRL_MASK      = 16'hFF01;
  localparam int          CTRL_FA_BIT    = 0;
  localparam int          CTRL_PAGE_LSB  = 8;
  localparam int          CTRL_PAGE_MSB  = 15;
  localparam int          STAT_BUSY_BIT  = 0;
  localparam int          STAT_BYTE_LSB  = 8;

  typedef enum logic [2:0] {
    CMD_NONE   = 3'h0,
    CMD_PUSH   = 3'h1,
    CMD_POP    = 3'h2,
    CMD_CALL   = 3'h3,
    CMD_EXC    = 3'h4,
    CMD_RET    = 3'h5,
    CMD_RETFIE = 3'h6
  } ssp_cmd_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WR2  = 3'h1,
    ST_FIN  = 3'h3,
    ST_RDA  = 3'h2,
    ST_RDB  = 3'h6,
    ST_RDC  = 3'h7
  } ssp_state_e;

endpackage

// ---- core/ssp_regbus_if.sv ----
interface ssp_regbus_if;
  logic [15:0] wdata;
  logic        sp_wr;
  logic        fp_wr;
  logic        hold;
  logic        frame_flag;
  logic [7:0]  page;
  logic [15:0] sp_val;
  logic [15:0] fp_val;
  logic [15:0] stat_val;
  logic        grant;

  modport slv (
    output wdata, sp_wr, fp_wr, hold, frame_flag, page,
    input  sp_val, fp_val, stat_val, grant
  );
  modport eng (
    input  wdata, sp_wr, fp_wr, hold, frame_flag, page,
    output sp_val, fp_val, stat_val, grant
  );
endinterface

// ---- core/ssp_ptr_reg.sv ----
module ssp_ptr_reg
  import ssp_pkg::*;
#(
  parameter int unsigned  W       = 16,
  parameter logic [W-1:0] RST_VAL = '0,
  parameter bit           ALIGN   = 1'b1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         step_up,
  input  wire logic         step_dn,
  output logic      [W-1:0] value
);
  localparam logic [W-1:0] STEP = W'(WORD_STEP);

  logic [W-1:0] value_q;
  logic [W-1:0] value_d;
  logic [W-1:0] masked;

  // Loaded low bit never stored as one while ALIGN is set; RST_VAL is stored unmasked
  assign masked  = ALIGN ? {load_val[W-1:1], 1'b0} : load_val;
  // Arithmetic wraps inside W bits, no page bits
  assign value_d = load    ? masked :
                   step_up ? value_q + STEP :
                   step_dn ? value_q - STEP : value_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      value_q <= RST_VAL;
    end else begin
      value_q <= value_d;
    end
  end

  assign value = value_q;
endmodule

// ---- core/ssp_apb_slave.sv ----
module ssp_apb_slave
  import ssp_pkg::*;
#(
  parameter int unsigned PADDR_W = 12
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  ssp_regbus_if.slv               rb
);
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic [15:0] ctrl_q;

  wire logic        access    = psel & penable;
  wire logic        hit_sp    = paddr == PADDR_W'(OFS_SP);
  wire logic        hit_fp    = paddr == PADDR_W'(OFS_FP);
  wire logic        hit_ctrl  = paddr == PADDR_W'(OFS_CTRL);
  wire logic        hit_stat  = paddr == PADDR_W'(OFS_STAT);
  wire logic        hit_any   = hit_sp | hit_fp | hit_ctrl | hit_stat;
  wire logic        wr_commit = access & pready_q & pwrite;
  wire logic [31:0] rd_mux    = hit_sp   ? {16'h0000, rb.sp_val} :
                                hit_fp   ? {16'h0000, rb.fp_val} :
                                hit_ctrl ? {16'h0000, ctrl_q} :
                                hit_stat ? {16'h0000, rb.stat_val} : 32'h0000_0000;

  // Wait states until the stack engine is idle
  assign rb.hold       = access & ~pready_q & rb.grant;
  assign rb.sp_wr      = wr_commit & hit_sp;
  assign rb.fp_wr      = wr_commit & hit_fp;
  assign rb.wdata      = pwdata[15:0];
  assign rb.frame_flag = ctrl_q[CTRL_FA_BIT];
  assign rb.page       = ctrl_q[CTRL_PAGE_MSB:CTRL_PAGE_LSB];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      ctrl_q    <= CTRL_RESET;
    end else begin
      pready_q  <= rb.hold;
      pslverr_q <= rb.hold & ~hit_any;
      if (rb.hold) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      end
      if (wr_commit & hit_ctrl) begin
        ctrl_q <= pwdata[15:0] & CTRL_MASK;
      end
    end
  end

  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign prdata  = prdata_q;
endmodule

// ---- core/ssp_stack_top.sv ----
// Functional notes
// - Stack pointer bit zero always reads zero
// - Every reset loads pointer with 0x1000
// - Pointer addresses next free word, grows upward
// - Push writes then increments; pop decrements first
// - PC low word first, upper bits second
// - Call push zeroes upper byte of word
// - Exception push puts status byte upper
// - Stack pointer never paged, sixteen bits only
// - Frame pointer unpaged while frame flag set
// - Engine updates pointer; instructions still access it
// - Software may write pointer anywhere
//
// Decided for this implementation: the APB register port and the register addresses.
module ssp_stack_top
  import ssp_pkg::*;
#(
  parameter int unsigned PADDR_W = 12
) (
  input  wire logic               CLK_SYS,
  input  wire logic               RST,
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [PADDR_W-1:0] PADDR,
  input  wire logic [31:0]        PWDATA,
  output logic      [31:0]        PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  input  wire logic               CORE_REQ,
  input  wire logic [2:0]         CORE_CMD,
  input  wire logic [15:0]        CORE_WDATA,
  input  wire logic [15:0]        CORE_PC_LO,
  input  wire logic [6:0]         CORE_PC_HI,
  input  wire logic [7:0]         CORE_STATUS_LOW_BYTE,
  input  wire logic               CORE_SP_WR,
  input  wire logic [15:0]        CORE_SP_WDATA,
  output logic                    CORE_READY,
  output logic                    CORE_DONE,
  output logic      [15:0]        CORE_RDATA,
  output logic      [15:0]        CORE_PC_LO_OUT,
  output logic      [6:0]         CORE_PC_HI_OUT,
  output logic      [7:0]         CORE_STATUS_LOW_BYTE_OUT,
  output logic                    CORE_STATUS_VALID,
  output logic      [15:0]        CORE_SP,
  output logic      [15:0]        MEM_ADDR,
  output logic      [15:0]        MEM_WDATA,
  output logic                    MEM_WE,
  output logic                    MEM_RE,
  input  wire logic [15:0]        MEM_RDATA,
  output logic      [23:0]        FP_ADDR
);
  ssp_regbus_if rb ();

  ssp_state_e  state_q;
  ssp_state_e  state_d;
  logic [15:0] sp_val;
  logic [15:0] fp_val;
  logic [15:0] addr_q;
  logic [15:0] addr_d;
  logic [15:0] wdata_q;
  logic [15:0] wdata_d;
  logic        we_q;
  logic        we_d;
  logic        re_q;
  logic        re_d;
  logic        done_q;
  logic        done_d;
  logic        sp_up;
  logic        sp_dn;
  logic        ready_q;
  logic        two_q;
  logic        exc_q;
  logic [15:0] hi_word_q;
  logic [15:0] rdata_q;
  logic [15:0] pc_lo_q;
  logic [6:0]  pc_hi_q;
  logic [7:0]  status_q;
  logic        status_valid_q;
  logic [23:0] fp_addr_q;

  wire logic        sp_wr_take = CORE_SP_WR & ready_q;
  wire logic        cmd_take   = CORE_REQ & ready_q & ~CORE_SP_WR;
  wire logic        is_call    = CORE_CMD == CMD_CALL;
  wire logic        is_exc     = CORE_CMD == CMD_EXC;
  wire logic        is_retfie  = CORE_CMD == CMD_RETFIE;
  wire logic        is_ret2    = (CORE_CMD == CMD_RET) | is_retfie;
  wire logic [15:0] sp_dec     = sp_val - WORD_STEP;
  wire logic        sp_load    = sp_wr_take | rb.sp_wr;
  wire logic [15:0] sp_load_v  = sp_wr_take ? CORE_SP_WDATA : rb.wdata;
  wire logic [15:0] call_hi    = {8'h00, 1'b0, CORE_PC_HI};
  wire logic [15:0] exc_hi     = {CORE_STATUS_LOW_BYTE, 1'b0, CORE_PC_HI};
  wire logic        idle_d     = state_d == ST_IDLE;

  assign rb.grant    = (state_q == ST_IDLE) & ~cmd_take & ~sp_wr_take;
  assign rb.sp_val   = sp_val;
  assign rb.fp_val   = fp_val;
  assign rb.stat_val = {status_q, 7'h00, state_q != ST_IDLE};

  ssp_apb_slave #(
    .PADDR_W (PADDR_W)
  ) u_apb (
    .clk     (CLK_SYS),
    .rst     (RST),
    .psel    (PSEL),
    .penable (PENABLE),
    .pwrite  (PWRITE),
    .paddr   (PADDR),
    .pwdata  (PWDATA),
    .prdata  (PRDATA),
    .pready  (PREADY),
    .pslverr (PSLVERR),
    .rb      (rb)
  );

  // Reset value points at valid RAM for early traps
  ssp_ptr_reg #(
    .W       (16),
    .RST_VAL (SP_RESET),
    .ALIGN   (1'b1)
  ) u_sp (
    .clk      (CLK_SYS),
    .rst      (RST),
    .load     (sp_load),
    .load_val (sp_load_v),
    .step_up  (sp_up),
    .step_dn  (sp_dn),
    .value    (sp_val)
  );

  ssp_ptr_reg #(
    .W       (16),
    .RST_VAL (FP_RESET),
    .ALIGN   (1'b0)
  ) u_fp (
    .clk      (CLK_SYS),
    .rst      (RST),
    .load     (rb.fp_wr),
    .load_val (rb.wdata),
    .step_up  (1'b0),
    .step_dn  (1'b0),
    .value    (fp_val)
  );

  always_comb begin
    state_d = state_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    we_d    = 1'b0;
    re_d    = 1'b0;
    done_d  = 1'b0;
    sp_up   = 1'b0;
    sp_dn   = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (cmd_take) begin
          case (CORE_CMD)
            CMD_PUSH: begin
              we_d    = 1'b1;
              addr_d  = sp_val;
              wdata_d = CORE_WDATA;
              sp_up   = 1'b1;
              state_d = ST_FIN;
            end
            CMD_CALL, CMD_EXC: begin
              we_d    = 1'b1;
              addr_d  = sp_val;
              wdata_d = CORE_PC_LO;
              sp_up   = 1'b1;
              state_d = ST_WR2;
            end
            CMD_POP, CMD_RET, CMD_RETFIE: begin
              re_d    = 1'b1;
              addr_d  = sp_dec;
              sp_dn   = 1'b1;
              state_d = ST_RDA;
            end
            default: begin
              done_d  = 1'b1;
            end
          endcase
        end
      end
      ST_WR2: begin
        we_d    = 1'b1;
        addr_d  = sp_val;
        wdata_d = hi_word_q;
        sp_up   = 1'b1;
        state_d = ST_FIN;
      end
      ST_FIN: begin
        done_d  = 1'b1;
        state_d = ST_IDLE;
      end
      ST_RDA: begin
        if (two_q) begin
          re_d   = 1'b1;
          addr_d = sp_dec;
          sp_dn  = 1'b1;
        end
        state_d = ST_RDB;
      end
      ST_RDB: begin
        if (two_q) begin
          state_d = ST_RDC;
        end else begin
          done_d  = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_RDC: begin
        done_d  = 1'b1;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_q <= ST_IDLE;
      addr_q  <= 16'h0000;
      wdata_q <= 16'h0000;
      we_q    <= 1'b0;
      re_q    <= 1'b0;
      done_q  <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      state_q <= state_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      we_q    <= we_d;
      re_q    <= re_d;
      done_q  <= done_d;
      ready_q <= idle_d & ~rb.hold;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      two_q     <= 1'b0;
      exc_q     <= 1'b0;
      hi_word_q <= 16'h0000;
    end else if (cmd_take) begin
      two_q     <= is_ret2;
      exc_q     <= is_retfie;
      hi_word_q <= is_exc ? exc_hi : call_hi;
    end
  end

  // Read data arrive one cycle after the read strobe
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rdata_q        <= 16'h0000;
      pc_lo_q        <= 16'h0000;
      pc_hi_q        <= 7'h00;
      status_q       <= 8'h00;
      status_valid_q <= 1'b0;
    end else begin
      status_valid_q <= 1'b0;
      if (state_q == ST_RDB) begin
        if (two_q) begin
          pc_hi_q <= MEM_RDATA[6:0];
          if (exc_q) begin
            status_q <= MEM_RDATA[15:8];
          end
        end else begin
          rdata_q <= MEM_RDATA;
        end
      end
      if (state_q == ST_RDC) begin
        pc_lo_q        <= MEM_RDATA;
        status_valid_q <= exc_q;
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      fp_addr_q <= 24'h00_0000;
    end else begin
      fp_addr_q <= {rb.frame_flag ? 8'h00 : rb.page, fp_val};
    end
  end

  assign CORE_READY               = ready_q;
  assign CORE_DONE                = done_q;
  assign CORE_RDATA               = rdata_q;
  assign CORE_PC_LO_OUT           = pc_lo_q;
  assign CORE_PC_HI_OUT           = pc_hi_q;
  assign CORE_STATUS_LOW_BYTE_OUT = status_q;
  assign CORE_STATUS_VALID        = status_valid_q;
  assign CORE_SP                  = sp_val;
  assign MEM_ADDR                 = addr_q;
  assign MEM_WDATA                = wdata_q;
  assign MEM_WE                   = we_q;
  assign MEM_RE                   = re_q;
  assign FP_ADDR                  = fp_addr_q;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  sp_align_a: assert property (CORE_SP[0] == 1'b0)
    else $error("stack pointer low bit set");
  sp_reset_a: assert property ($past(RST) |-> CORE_SP == SP_RESET)
    else $error("stack pointer not at reset value");
  next_free_a: assert property (MEM_WE |-> CORE_SP == MEM_ADDR + WORD_STEP)
    else $error("pointer not at next free word");
  push_post_a: assert property (cmd_take && CORE_CMD == CMD_PUSH |=>
    MEM_WE && MEM_ADDR == $past(CORE_SP) && CORE_SP == $past(CORE_SP) + WORD_STEP)
    else $error("push did not write then increment");
  pop_pre_a: assert property (cmd_take && CORE_CMD == CMD_POP |=>
    MEM_RE && MEM_ADDR == $past(CORE_SP) - WORD_STEP && CORE_SP == MEM_ADDR)
    else $error("pop did not decrement first");
  pc_order_a: assert property (cmd_take && (is_call || is_exc) |=>
    MEM_WE && MEM_WDATA == $past(CORE_PC_LO) ##1
    MEM_WE && MEM_ADDR == $past(MEM_ADDR) + WORD_STEP)
    else $error("program counter words out of order");
  call_zero_a: assert property (cmd_take && is_call |=> ##1
    MEM_WDATA[15:7] == 9'h000 && MEM_WDATA[6:0] == $past(CORE_PC_HI, 2))
    else $error("call upper word not zero filled");
  exc_status_a: assert property (cmd_take && is_exc |=> ##1
    MEM_WDATA[15:8] == $past(CORE_STATUS_LOW_BYTE, 2) &&
    MEM_WDATA[6:0] == $past(CORE_PC_HI, 2))
    else $error("exception word lacks status byte");
  fp_range_a: assert property ($past(rb.frame_flag) |-> FP_ADDR[23:16] == 8'h00)
    else $error("frame pointer paged while flag set");
  done_bound_a: assert property (cmd_take |-> ##[1:4] CORE_DONE)
    else $error("stack operation did not finish");
  sw_write_a: assert property (sp_wr_take |=>
    CORE_SP == ($past(CORE_SP_WDATA) & 16'hFFFE))
    else $error("software pointer write lost");
  ret_order_a: assert property (cmd_take && is_ret2 |=>
    MEM_RE ##1 MEM_RE && MEM_ADDR == $past(MEM_ADDR) - WORD_STEP)
    else $error("return pops out of order");

  push_c: cover property (cmd_take && CORE_CMD == CMD_PUSH ##2 CORE_DONE);
  call_c: cover property (cmd_take && is_call ##3 CORE_DONE);
  retfie_c: cover property (cmd_take && is_retfie ##4 CORE_STATUS_VALID);
  apb_sp_c: cover property (rb.sp_wr);
endmodule

// ---- testbench/ssp_mem_model.sv ----
module ssp_mem_model (
  input  wire logic        clk,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic        we,
  input  wire logic        re,
  output logic      [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:65535];
  initial rdata = 16'h0000;
  // Read word stands one cycle only; afterwards the bus keeps toggling
  always @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    if (re) begin
      rdata <= mem[addr];
    end else begin
      rdata <= ~rdata;
    end
  end
endmodule

// ---- testbench/ssp_stack_top_tb.sv ----
module ssp_stack_top_tb;
  import ssp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        core_req = 1'b0;
  logic [2:0]  core_cmd = 3'h0;
  logic [15:0] core_wdata = 16'h0000;
  logic [15:0] pc_lo = 16'h0000;
  logic [6:0]  pc_hi = 7'h00;
  logic [7:0]  sbyte = 8'h00;
  logic        sp_wr = 1'b0;
  logic        core_ready;
  logic        core_done;
  logic [15:0] core_rdata;
  logic [15:0] pc_lo_out;
  logic [6:0]  pc_hi_out;
  logic [7:0]  sbyte_out;
  logic        status_valid;
  logic [15:0] core_sp;
  logic [15:0] mem_addr;
  logic [15:0] mem_wdata;
  logic        mem_we;
  logic        mem_re;
  logic [15:0] mem_rdata;
  logic [23:0] fp_addr;
  logic [31:0] rd;
  logic        er;
  int          errors = 0;
  int          compares = 0;

  always #10 clk_sys = ~clk_sys;

  ssp_stack_top ssp_stack_top_i (
    .CLK_SYS(clk_sys), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CORE_REQ(core_req), .CORE_CMD(core_cmd), .CORE_WDATA(core_wdata),
    .CORE_PC_LO(pc_lo), .CORE_PC_HI(pc_hi), .CORE_STATUS_LOW_BYTE(sbyte),
    .CORE_SP_WR(sp_wr), .CORE_SP_WDATA(core_wdata), .CORE_READY(core_ready),
    .CORE_DONE(core_done), .CORE_RDATA(core_rdata), .CORE_PC_LO_OUT(pc_lo_out),
    .CORE_PC_HI_OUT(pc_hi_out), .CORE_STATUS_LOW_BYTE_OUT(sbyte_out),
    .CORE_STATUS_VALID(status_valid), .CORE_SP(core_sp), .MEM_ADDR(mem_addr),
    .MEM_WDATA(mem_wdata), .MEM_WE(mem_we), .MEM_RE(mem_re), .MEM_RDATA(mem_rdata),
    .FP_ADDR(fp_addr)
  );

  ssp_mem_model ssp_mem_model_i (
    .clk(clk_sys), .addr(mem_addr), .wdata(mem_wdata), .we(mem_we), .re(mem_re),
    .rdata(mem_rdata)
  );

  task automatic tally_and_finish();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang_check(input logic ok);
    if (!ok) begin
      errors++;
      tally_and_finish();
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    logic r;
    int   n;
    r = 1'b0;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Request holds until pready is seen high at a rising edge
    while (!r && n < 50) begin
      @(posedge clk_sys);
      r = (pready === 1'b1);
      q = prdata;
      e = pslverr;
      n++;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    hang_check(r);
  endtask

  // One core request; returns in the completion cycle, or after the pointer write
  task automatic core(input logic [2:0] cmd, input logic [15:0] wd, input logic [15:0] pl,
                      input logic [6:0] ph, input logic [7:0] sb, input logic spw);
    logic r;
    int   n;
    r = 1'b0;
    n = 0;
    @(posedge clk_sys);
    core_cmd <= cmd;
    core_wdata <= wd;
    pc_lo <= pl;
    pc_hi <= ph;
    sbyte <= sb;
    core_req <= !spw;
    sp_wr <= spw;
    // Request holds until ready is seen high at a rising edge
    while (!r && n < 50) begin
      @(posedge clk_sys);
      r = (core_ready === 1'b1);
      n++;
    end
    core_req <= 1'b0;
    sp_wr <= 1'b0;
    hang_check(r);
    r = spw;
    n = 0;
    while (!r && n < 50) begin
      @(posedge clk_sys);
      r = (core_done === 1'b1);
      n++;
    end
    hang_check(r);
    if (spw) begin
      @(posedge clk_sys);
    end
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk(32'(core_sp), 32'h0000_1000);
    apb(1'b0, OFS_SP, 32'h0000_0000, rd, er);
    chk(rd, 32'h0000_1000);
    apb(1'b1, OFS_SP, 32'h0000_2003, rd, er);
    apb(1'b0, OFS_SP, 32'h0000_0000, rd, er);
    chk(rd, 32'h0000_2002);
    chk(32'(core_sp), 32'h0000_2002);
    core(CMD_PUSH, 16'hA5A5, 16'h0000, 7'h00, 8'h00, 1'b0);
    chk(32'(ssp_mem_model_i.mem[16'h2002]), 32'h0000_A5A5);
    core(CMD_PUSH, 16'h5A5A, 16'h0000, 7'h00, 8'h00, 1'b0);
    chk(32'(core_sp), 32'h0000_2006);
    core(CMD_POP, 16'h0000, 16'h0000, 7'h00, 8'h00, 1'b0);
    chk(32'(core_rdata), 32'h0000_5A5A);
    core(CMD_POP, 16'h0000, 16'h0000, 7'h00, 8'h00, 1'b0);
    chk(32'(core_rdata), 32'h0000_A5A5);
    chk(32'(core_sp), 32'h0000_2002);
    core(CMD_CALL, 16'h0000, 16'h1234, 7'h55, 8'hCC, 1'b0);
    chk(32'(ssp_mem_model_i.mem[16'h2002]), 32'h0000_1234);
    chk(32'(ssp_mem_model_i.mem[16'h2004]), 32'h0000_0055);
    core(CMD_EXC, 16'h0000, 16'h3456, 7'h2A, 8'hCC, 1'b0);
    chk(32'(ssp_mem_model_i.mem[16'h2006]), 32'h0000_3456);
    chk(32'(ssp_mem_model_i.mem[16'h2008]), 32'h0000_CC2A);
    chk(32'(core_sp), 32'h0000_200A);
    core(CMD_RETFIE, 16'h0000, 16'h0000, 7'h00, 8'h00, 1'b0);
    chk(32'(status_valid), 32'h0000_0001);
    chk(32'({pc_hi_out, pc_lo_out}), 32'h002A_3456);
    chk(32'(sbyte_out), 32'h0000_00CC);
    apb(1'b0, OFS_STAT, 32'h0000_0000, rd, er);
    chk(32'(rd[15:8]), 32'h0000_00CC);
    core(CMD_RET, 16'h0000, 16'h0000, 7'h00, 8'h00, 1'b0);
    chk(32'({pc_hi_out, pc_lo_out}), 32'h0055_1234);
    chk(32'(core_sp), 32'h0000_2002);
    core(CMD_NONE, 16'hFFFF, 16'h0000, 7'h00, 8'h00, 1'b1);
    chk(32'(core_sp), 32'h0000_FFFE);
    core(CMD_PUSH, 16'h0F0F, 16'h0000, 7'h00, 8'h00, 1'b0);
    chk(32'(ssp_mem_model_i.mem[16'hFFFE]), 32'h0000_0F0F);
    chk(32'(core_sp), 32'h0000_0000);
    core(3'h7, 16'h0000, 16'h0000, 7'h00, 8'h00, 1'b0);
    chk(32'(core_sp), 32'h0000_0000);
    apb(1'b1, OFS_CTRL, 32'h0000_1200, rd, er);
    apb(1'b1, OFS_FP, 32'h0000_4001, rd, er);
    repeat (2) @(negedge clk_sys);
    chk(32'(fp_addr), 32'h0012_4001);
    apb(1'b1, OFS_CTRL, 32'h0000_1201, rd, er);
    repeat (2) @(negedge clk_sys);
    chk(32'(fp_addr), 32'h0000_4001);
    chk(32'(er), 32'h0000_0000);
    apb(1'b0, OFS_FP, 32'h0000_0000, rd, er);
    chk(rd, 32'h0000_4001);
    apb(1'b0, 12'h010, 32'h0000_0000, rd, er);
    chk(32'(er), 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk(32'(core_sp), 32'h0000_1000);
    apb(1'b0, OFS_CTRL, 32'h0000_0000, rd, er);
    chk(rd, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
